// *** dram_mode_device.sv ***
// device end: decodes mode register writes and runs bursts in that mode
// assumes pins are synchronous to mclk and the controller keeps its own obligations
`timescale 1ns/1ps

module dram_mode_device (
	input  wire logic        mclk,
	input  wire logic        reset,
	dram_cmd_if.device       bus,
	output logic      [5:0]  cas_latency,
	output logic      [5:0]  read_latency_total,
	output logic      [1:0]  burst_mode,
	output logic             burst_interleave,
	output logic             test_mode,
	output logic             dll_reset_bit,
	output logic      [4:0]  write_recovery_cycles,
	output logic      [5:0]  autoprecharge_write_delay,
	output logic             fast_powerdown_exit,
	output logic             dll_running,
	output logic      [1:0]  drive_select,
	output logic      [2:0]  rtt_nom_code,
	output logic      [1:0]  rtt_wr_code,
	output logic             internal_write_start
);

	typedef struct packed {
		dram_mode_pkg::dev_state_type st;
		logic [3:0]       cl_code;
		logic [5:0]       cl;
		logic [1:0]       al_code;
		logic [5:0]       rl;
		logic [1:0]       bl;
		logic             interleave;
		logic             test;
		logic             dll_rst;
		logic [4:0]       wr;
		logic [5:0]       apwd;
		logic             pd_fast;
		logic             dll_dis;
		logic [1:0]       drive;
		logic [2:0]       nom;
		logic [1:0]       rtt_wr;
		logic [5:0]       cnt;
		logic [2:0]       beat;
		logic             is_read;
		logic             chop;
		logic [2:0]       start;
		logic [7:0]       dq;
		logic             dq_oe;
		logic             dqs;
		logic             wr_start;
		logic             cke_prev;
		logic             in_sref;
		logic             in_pd;
		logic             dll_on;
		logic [7:0][7:0]  mem;
	} dev_regs_type;

	dev_regs_type r;
	dev_regs_type n;

	always_comb begin
		logic       valid;
		logic       mrs;
		logic       rd;
		logic       wr;
		logic       refr;
		logic       act;
		logic [2:0] pos;
		logic [2:0] col;
		valid = 1'b0;
		mrs = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		refr = 1'b0;
		act = 1'b0;
		pos = 3'h0;
		col = 3'h0;
		n = r;
		n.dll_rst = 1'b0;
		n.wr_start = 1'b0;
		n.dq_oe = 1'b0;
		n.cke_prev = bus.cke;

		// a command counts only with clock enable high on the edge before
		valid = r.cke_prev & ~bus.cs_n;
		mrs = valid & bus.cke & ~bus.ras_n & ~bus.cas_n & ~bus.we_n;
		refr = valid & ~bus.ras_n & ~bus.cas_n & bus.we_n;
		rd = valid & bus.cke & bus.ras_n & ~bus.cas_n & bus.we_n;
		wr = valid & bus.cke & bus.ras_n & ~bus.cas_n & ~bus.we_n;

		// fields other than the self-clearing dll reset bit move only on a registered write to their own register
		if (mrs && r.st == dram_mode_pkg::DEV_IDLE) begin
			if (bus.ba == dram_mode_pkg::BA_MR0) begin
				n.cl_code = {bus.a[dram_mode_pkg::CL_LO_BIT],
					bus.a[dram_mode_pkg::CL_HI_LSB +: 3]};
				n.bl = bus.a[dram_mode_pkg::BL_LSB +: 2];
				n.interleave = bus.a[dram_mode_pkg::TYPE_BIT];
				n.test = bus.a[dram_mode_pkg::TEST_BIT];
				n.dll_rst = bus.a[dram_mode_pkg::DLLRST_BIT];
				n.wr = dram_mode_pkg::WR_BASE + {2'h0, bus.a[dram_mode_pkg::WR_LSB +: 3]};
				n.pd_fast = bus.a[dram_mode_pkg::PD_BIT];
			end else if (bus.ba == dram_mode_pkg::BA_MR1) begin
				n.dll_dis = bus.a[dram_mode_pkg::DLL_DIS_BIT];
				n.drive = {bus.a[dram_mode_pkg::DRV_HI_BIT],
					bus.a[dram_mode_pkg::DRV_LO_BIT]};
				n.al_code = bus.a[dram_mode_pkg::AL_LSB +: 2];
				n.nom = {bus.a[dram_mode_pkg::NOM_B2], bus.a[dram_mode_pkg::NOM_B1],
					bus.a[dram_mode_pkg::NOM_B0]};
			end else if (bus.ba == dram_mode_pkg::BA_MR2) begin
				n.rtt_wr = bus.a[dram_mode_pkg::RTTWR_LSB +: 2];
			end
		end
		n.cl = dram_mode_pkg::cl_cycles(n.cl_code);
		n.rl = dram_mode_pkg::al_cycles(n.al_code, n.cl) + n.cl;
		n.apwd = {1'b0, n.wr} + 6'(dram_mode_pkg::PRECHARGE_CYCLES);

		// self refresh and power-down follow the clock enable
		if (refr && !bus.cke)
			n.in_sref = 1'b1;
		else if (r.in_sref && bus.cke)
			n.in_sref = 1'b0;
		if (r.cke_prev && !bus.cke && !refr && !r.in_sref)
			n.in_pd = 1'b1;
		else if (bus.cke)
			n.in_pd = 1'b0;
		// dll drops in self refresh without any register write
		n.dll_on = ~n.dll_dis & ~n.in_sref & ~(n.in_pd & ~n.pd_fast);

		case (r.st)
			dram_mode_pkg::DEV_IDLE: begin
				if (rd || wr) begin
					n.is_read = rd;
					n.chop = (r.bl == dram_mode_pkg::BL_FIXED4) ||
						(r.bl == dram_mode_pkg::BL_OTF && !bus.a[dram_mode_pkg::CHOP_SEL_BIT]);
					n.start = rd ? bus.a[2:0] : {bus.a[2], 2'h0};
					// write beats arrive a cycle ahead and are taken at the edge ending them
					n.cnt = r.rl - 6'h01;
					n.st = dram_mode_pkg::DEV_WAIT;
				end
			end
			dram_mode_pkg::DEV_WAIT: begin
				if (r.cnt == 6'h00) begin
					act = 1'b1;
					pos = 3'h0;
				end else begin
					n.cnt = r.cnt - 6'h01;
				end
			end
			dram_mode_pkg::DEV_BURST: begin
				act = 1'b1;
				pos = r.beat;
			end
			default: begin
				n.st = dram_mode_pkg::DEV_IDLE;
			end
		endcase

		if (act) begin
			if (r.is_read) begin
				col = dram_mode_pkg::beat_column(r.start, pos, r.interleave);
				if (!r.chop || !pos[2]) begin
					n.dq = r.mem[col];
					n.dq_oe = 1'b1;
					n.dqs = ~pos[0];
				end
			end else begin
				col = r.chop ? {r.start[2], pos[1:0]} : pos;
				if (!r.chop || !pos[2])
					n.mem[col] = bus.dq;
				if (pos == ((r.bl == dram_mode_pkg::BL_FIXED4) ? dram_mode_pkg::WR_START_BC4
					: dram_mode_pkg::WR_START_BL8))
					n.wr_start = 1'b1;
			end
			n.beat = pos + 3'h1;
			n.st = (pos == 3'(dram_mode_pkg::BURST_BEATS - 1)) ? dram_mode_pkg::DEV_IDLE
				: dram_mode_pkg::DEV_BURST;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// strobe and data enable travel together so the line never half-drives
	assign bus.dq_d              = r.dq;
	assign bus.dq_d_oe           = r.dq_oe;
	assign bus.dqs_d             = r.dqs;
	assign bus.dqs_d_oe          = r.dq_oe;
	assign cas_latency           = r.cl;
	assign read_latency_total    = r.rl;
	assign burst_mode            = r.bl;
	assign burst_interleave      = r.interleave;
	assign test_mode             = r.test;
	assign dll_reset_bit         = r.dll_rst;
	assign write_recovery_cycles = r.wr;
	assign autoprecharge_write_delay = r.apwd;
	assign fast_powerdown_exit   = r.pd_fast;
	assign dll_running           = r.dll_on;
	assign drive_select          = r.drive;
	assign rtt_nom_code          = r.nom;
	assign rtt_wr_code           = r.rtt_wr;
	assign internal_write_start  = r.wr_start;

endmodule // dram_mode_device

// *** dram_mode_pkg.sv ***
// shared constants, codes and decode helpers for the mode-register link
// assumes one 100 MHz clock on both ends; one data beat per clock
package dram_mode_pkg;

	localparam int CLK_PERIOD_NS = 10;

	// bank codes that pick the mode register
	localparam logic [2:0] BA_MR0 = 3'h0;
	localparam logic [2:0] BA_MR1 = 3'h1;
	localparam logic [2:0] BA_MR2 = 3'h2;

	// burst_latency_config_reg field positions
	localparam int BL_LSB       = 0;
	localparam int CL_LO_BIT    = 2;
	localparam int TYPE_BIT     = 3;
	localparam int CL_HI_LSB    = 4;
	localparam int TEST_BIT     = 7;
	localparam int DLLRST_BIT   = 8;
	localparam int WR_LSB       = 9;
	localparam int PD_BIT       = 12;
	localparam int CHOP_SEL_BIT = 12;

	// dll_drive_config_reg and refresh_term_config_reg field positions
	localparam int DLL_DIS_BIT = 0;
	localparam int DRV_LO_BIT  = 1;
	localparam int NOM_B0      = 2;
	localparam int AL_LSB      = 3;
	localparam int DRV_HI_BIT  = 5;
	localparam int NOM_B1      = 6;
	localparam int WLEV_BIT    = 7;
	localparam int NOM_B2      = 9;
	localparam int QOFF_BIT    = 12;
	localparam int RTTWR_LSB   = 9;

	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF    = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;

	// allowed nominal termination codes, {A9,A6,A2}
	localparam logic [2:0] RTT_RZQ4 = 3'h1;
	localparam logic [2:0] RTT_RZQ2 = 3'h2;
	localparam logic [2:0] RTT_RZQ6 = 3'h3;

	localparam logic [5:0] CL_BASE         = 6'h04;
	localparam logic [4:0] WR_BASE         = 5'h05;
	localparam int         BURST_BEATS     = 8;
	localparam int         CHOP_PULL_IN    = 2;
	localparam logic [2:0] WR_START_BL8    = 3'(BURST_BEATS - 1);
	localparam logic [2:0] WR_START_BC4    = 3'(BURST_BEATS - 1 - CHOP_PULL_IN);

	// times in ns and the derived least cycle counts
	localparam int WRITE_RECOVERY_TIME_NS = 15;
	localparam int PRECHARGE_PERIOD_NS    = 14;
	localparam int SLOW_PD_EXIT_NS        = 24;
	localparam int FAST_PD_EXIT_NS        = 6;
	localparam int WR_MIN_CYCLES    = (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRECHARGE_CYCLES = (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOW_PD_CYCLES   = (SLOW_PD_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAST_PD_CYCLES   = (FAST_PD_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLL_LOCK_CYCLES  = 512;
	localparam int MODE_GAP_CYCLES  = 4;
	localparam logic [2:0] WR_MIN_CODE =
		(WR_MIN_CYCLES > int'(WR_BASE)) ? 3'(WR_MIN_CYCLES - int'(WR_BASE)) : 3'h0;

	// controller command codes and register offsets
	localparam logic [2:0] CMD_NOP       = 3'h0;
	localparam logic [2:0] CMD_MRS       = 3'h1;
	localparam logic [2:0] CMD_READ      = 3'h2;
	localparam logic [2:0] CMD_WRITE     = 3'h3;
	localparam logic [2:0] CMD_SREF_IN   = 3'h4;
	localparam logic [2:0] CMD_SREF_OUT  = 3'h5;
	localparam logic [2:0] CMD_PD_IN     = 3'h6;
	localparam logic [2:0] CMD_PD_OUT    = 3'h7;
	localparam logic [4:0] REG_ADDR      = 5'h00;
	localparam logic [4:0] REG_CMD       = 5'h04;
	localparam logic [4:0] REG_WDATA_LO  = 5'h08;
	localparam logic [4:0] REG_WDATA_HI  = 5'h0c;
	localparam logic [4:0] REG_RDATA_LO  = 5'h10;
	localparam logic [4:0] REG_RDATA_HI  = 5'h14;
	localparam logic [4:0] REG_STATUS    = 5'h18;

	typedef enum logic [1:0] {DEV_IDLE, DEV_WAIT, DEV_BURST} dev_state_type;
	typedef enum logic [1:0] {HOST_IDLE, HOST_WAIT, HOST_DATA, HOST_GAP} host_state_type;

	function automatic logic [5:0] cl_cycles(input logic [3:0] code);
		return CL_BASE + {2'h0, code};
	endfunction

	function automatic logic [5:0] al_cycles(input logic [1:0] code, input logic [5:0] cl);
		case (code)
			2'h1: return cl - 6'h01;
			2'h2: return cl - 6'h02;
			default: return 6'h00;
		endcase
	endfunction

	// column of read beat pos for a given start column and burst type
	function automatic logic [2:0] beat_column(input logic [2:0] start, input logic [2:0] pos,
		input logic interleave);
		logic [1:0] low;
		low = start[1:0] + pos[1:0];
		if (interleave)
			return start ^ pos;
		return {start[2] ^ pos[2], low};
	endfunction

endpackage

// *** dram_cmd_if.sv ***
// command, address and data link between controller and mode-decoding device
// assumes both ends share mclk; the bidirectional lines resolve here from the enables
`timescale 1ns/1ps
interface dram_cmd_if;
	logic       cke;
	logic       cs_n;
	logic       ras_n;
	logic       cas_n;
	logic       we_n;
	logic       odt;
	logic [2:0] ba;
	logic [15:0] a;
	logic [7:0] dq_h;
	logic       dq_h_oe;
	logic       dqs_h;
	logic       dqs_h_oe;
	logic [7:0] dq_d;
	logic       dq_d_oe;
	logic       dqs_d;
	logic       dqs_d_oe;
	logic [7:0] dq;
	logic       dqs;

	// an undriven line reads as zero
	assign dq  = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : 8'h00);
	assign dqs = dqs_d_oe ? dqs_d : (dqs_h_oe ? dqs_h : 1'b0);

	modport device (input cke, cs_n, ras_n, cas_n, we_n, odt, ba, a, dq, dqs,
		output dq_d, dq_d_oe, dqs_d, dqs_d_oe);
	modport host (output cke, cs_n, ras_n, cas_n, we_n, odt, ba, a, dq_h, dq_h_oe, dqs_h,
		dqs_h_oe, input dq, dqs);
endinterface

// *** dram_mode_controller.sv ***
// controller end: takes orders over a small register port and drives the link
// assumes the device end on the same mclk; odt is held low throughout
`timescale 1ns/1ps
module dram_mode_controller (
	input  wire logic        mclk,
	input  wire logic        reset,
	dram_cmd_if.host         bus,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata
);

	typedef struct packed {
		dram_mode_pkg::host_state_type st;
		logic [9:0]  cnt;
		logic [2:0]  beat;
		logic        is_read;
		logic        chop;
		logic        cke;
		logic        cs_n;
		logic        ras_n;
		logic        cas_n;
		logic        we_n;
		logic [2:0]  ba;
		logic [15:0] a;
		logic [7:0]  dq;
		logic        dq_oe;
		logic        dqs;
		logic [1:0]  bl;
		logic [5:0]  cl;
		logic [1:0]  al;
		logic        pd_fast;
		logic        dll_off;
		logic [18:0] addr;
		logic [63:0] wdata;
		logic [63:0] rdata;
		logic [31:0] rd_out;
	} host_regs_type;

	host_regs_type r;
	host_regs_type n;

	always_comb begin
		logic [2:0]  kind;
		logic [15:0] a;
		logic [2:0]  nom;
		logic [5:0]  rl;
		logic        busy;
		kind = reg_wdata[2:0];
		a = r.addr[15:0];
		nom = {a[dram_mode_pkg::NOM_B2], a[dram_mode_pkg::NOM_B1], a[dram_mode_pkg::NOM_B0]};
		rl = dram_mode_pkg::al_cycles(r.al, r.cl) + r.cl;
		busy = (r.st != dram_mode_pkg::HOST_IDLE);
		n = r;
		{n.cs_n, n.ras_n, n.cas_n, n.we_n} = 4'hf;
		n.dq_oe = 1'b0;

		n.rd_out = 32'h0;
		if (reg_rd) begin
			if (reg_addr == dram_mode_pkg::REG_ADDR)
				n.rd_out = {13'h0, r.addr};
			else if (reg_addr == dram_mode_pkg::REG_WDATA_LO)
				n.rd_out = r.wdata[31:0];
			else if (reg_addr == dram_mode_pkg::REG_WDATA_HI)
				n.rd_out = r.wdata[63:32];
			else if (reg_addr == dram_mode_pkg::REG_RDATA_LO)
				n.rd_out = r.rdata[31:0];
			else if (reg_addr == dram_mode_pkg::REG_RDATA_HI)
				n.rd_out = r.rdata[63:32];
			else if (reg_addr == dram_mode_pkg::REG_STATUS)
				n.rd_out = {29'h0, r.dll_off, r.cke, busy};
		end
		if (reg_wr) begin
			if (reg_addr == dram_mode_pkg::REG_ADDR)
				n.addr = reg_wdata[18:0];
			else if (reg_addr == dram_mode_pkg::REG_WDATA_LO)
				n.wdata[31:0] = reg_wdata;
			else if (reg_addr == dram_mode_pkg::REG_WDATA_HI)
				n.wdata[63:32] = reg_wdata;
		end

		// orders arriving while busy are dropped, which also keeps cke high during lock
		if (reg_wr && reg_addr == dram_mode_pkg::REG_CMD && !busy) begin
			n.st = dram_mode_pkg::HOST_GAP;
			n.cnt = 10'(dram_mode_pkg::MODE_GAP_CYCLES);
			n.ba = r.addr[18:16];
			n.a = a;
			if (kind == dram_mode_pkg::CMD_MRS) begin
				{n.cs_n, n.ras_n, n.cas_n, n.we_n} = 4'h0;
				if (r.addr[18:16] == dram_mode_pkg::BA_MR0) begin
					n.a[dram_mode_pkg::TEST_BIT] = 1'b0;
					if (a[dram_mode_pkg::WR_LSB +: 3] < dram_mode_pkg::WR_MIN_CODE)
						n.a[dram_mode_pkg::WR_LSB +: 3] = dram_mode_pkg::WR_MIN_CODE;
					n.bl = a[dram_mode_pkg::BL_LSB +: 2];
					n.cl = dram_mode_pkg::cl_cycles({a[dram_mode_pkg::CL_LO_BIT],
						a[dram_mode_pkg::CL_HI_LSB +: 3]});
					n.pd_fast = a[dram_mode_pkg::PD_BIT];
					if (a[dram_mode_pkg::DLLRST_BIT])
						n.cnt = 10'(dram_mode_pkg::DLL_LOCK_CYCLES);
				end else if (r.addr[18:16] == dram_mode_pkg::BA_MR1) begin
					n.ba = dram_mode_pkg::BA_MR1;
					n.al = a[dram_mode_pkg::AL_LSB +: 2];
					n.dll_off = a[dram_mode_pkg::DLL_DIS_BIT];
					// termination left off with the dll disabled, or where the code would be unsupported unless the WLEV and QOFF bits are both set
					if (a[dram_mode_pkg::DLL_DIS_BIT] ||
						(!(a[dram_mode_pkg::WLEV_BIT] && a[dram_mode_pkg::QOFF_BIT]) &&
						nom != dram_mode_pkg::RTT_RZQ2 && nom != dram_mode_pkg::RTT_RZQ4 &&
						nom != dram_mode_pkg::RTT_RZQ6)) begin
						n.a[dram_mode_pkg::NOM_B0] = 1'b0;
						n.a[dram_mode_pkg::NOM_B1] = 1'b0;
						n.a[dram_mode_pkg::NOM_B2] = 1'b0;
					end
				end else if (r.addr[18:16] == dram_mode_pkg::BA_MR2 && r.dll_off) begin
					n.a[dram_mode_pkg::RTTWR_LSB +: 2] = 2'h0;
				end
			end else if (kind == dram_mode_pkg::CMD_READ || kind == dram_mode_pkg::CMD_WRITE) begin
				n.is_read = (kind == dram_mode_pkg::CMD_READ);
				n.chop = (r.bl == dram_mode_pkg::BL_FIXED4) ||
					(r.bl == dram_mode_pkg::BL_OTF && reg_wdata[3]);
				n.a[dram_mode_pkg::CHOP_SEL_BIT] = ~reg_wdata[3];
				{n.cs_n, n.ras_n, n.cas_n, n.we_n} = {3'h2, n.is_read};
				n.st = dram_mode_pkg::HOST_WAIT;
				n.cnt = n.is_read ? 10'(rl) + 10'h1 : 10'(rl) - 10'h1;
			end else if (kind == dram_mode_pkg::CMD_SREF_IN) begin
				{n.cs_n, n.ras_n, n.cas_n, n.we_n} = 4'h1;
				n.cke = 1'b0;
			end else if (kind == dram_mode_pkg::CMD_PD_IN) begin
				n.cke = 1'b0;
			end else if (kind == dram_mode_pkg::CMD_SREF_OUT) begin
				n.cke = 1'b1;
				n.cnt = 10'(dram_mode_pkg::DLL_LOCK_CYCLES);
			end else if (kind == dram_mode_pkg::CMD_PD_OUT) begin
				n.cke = 1'b1;
				n.cnt = r.pd_fast ? 10'(dram_mode_pkg::FAST_PD_CYCLES)
					: 10'(dram_mode_pkg::SLOW_PD_CYCLES);
			end
		end

		case (r.st)
			dram_mode_pkg::HOST_WAIT, dram_mode_pkg::HOST_DATA: begin
				if (r.st == dram_mode_pkg::HOST_WAIT && r.cnt != 10'h0) begin
					n.cnt = r.cnt - 10'h1;
				end else begin
					if (r.is_read) begin
						if (!r.chop || !r.beat[2])
							n.rdata[{r.beat, 3'h0} +: 8] = bus.dq;
					end else begin
						n.dq = r.wdata[{r.beat, 3'h0} +: 8];
						n.dq_oe = 1'b1;
						n.dqs = ~r.beat[0];
					end
					n.beat = r.beat + 3'h1;
					n.st = dram_mode_pkg::HOST_DATA;
					if (r.beat == 3'(dram_mode_pkg::BURST_BEATS - 1)) begin
						n.st = dram_mode_pkg::HOST_GAP;
						n.cnt = 10'(dram_mode_pkg::MODE_GAP_CYCLES);
					end
				end
			end
			dram_mode_pkg::HOST_GAP: begin
				if (r.cnt == 10'h0)
					n.st = dram_mode_pkg::HOST_IDLE;
				else
					n.cnt = r.cnt - 10'h1;
			end
			default: begin
				n.beat = 3'h0;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign bus.cke      = r.cke;
	assign bus.cs_n     = r.cs_n;
	assign bus.ras_n    = r.ras_n;
	assign bus.cas_n    = r.cas_n;
	assign bus.we_n     = r.we_n;
	assign bus.odt      = 1'b0;
	assign bus.ba       = r.ba;
	assign bus.a        = r.a;
	assign bus.dq_h     = r.dq;
	assign bus.dq_h_oe  = r.dq_oe;
	assign bus.dqs_h    = r.dqs;
	assign bus.dqs_h_oe = r.dq_oe;
	assign reg_rdata    = r.rd_out;

endmodule // dram_mode_controller

// *** dram_mode_asserts.sv ***
// link assertions: mode writes, lock wait, termination codes, read bursts
// assumes plain interface signals on mclk, instantiated beside the link
`timescale 1ns/1ps
module dram_mode_asserts (
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic        cke,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic        odt,
	input wire logic [2:0]  ba,
	input wire logic [15:0] a,
	input wire logic        dq_d_oe,
	input wire logic        dqs_d
);
	logic [9:0] idle_r;
	logic       lock_r;
	logic       off_r;
	logic [1:0] bl_r;
	logic       chop_r;
	wire        cmd = cke && !cs_n;
	wire        mrs = cmd && {ras_n, cas_n, we_n} == 3'h0;
	wire        rd_cmd = cmd && ras_n && !cas_n && we_n;
	wire  [2:0] nom = {a[9], a[6], a[2]};
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// idle count saturates so a long quiet spell never wraps into a false short gap
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			idle_r <= 10'h3ff;
			lock_r <= 1'h0;
			off_r  <= 1'h0;
			bl_r   <= 2'h0;
			chop_r <= 1'h0;
		end else begin
			bl_r   <= (mrs && ba == 3'h0) ? a[1:0] : bl_r;
			chop_r <= rd_cmd ? (bl_r == 2'h2 || (bl_r == 2'h1 && !a[12])) : chop_r;
			idle_r <= cmd ? 10'h000 : idle_r + {9'h000, idle_r != 10'h3ff};
			lock_r <= cmd ? (mrs && ba == 3'h0 && a[8]) : lock_r;
			off_r  <= (mrs && ba == 3'h1) ? a[0] : off_r;
		end
	end
	sequence beat_pair; dqs_d ##1 !dqs_d; endsequence
	sequence first_half; dq_d_oe [*4]; endsequence
	sequence second_half_off; !dq_d_oe [*4]; endsequence
	chk_lock_wait: assert property (cmd && lock_r |-> idle_r >= 10'h1ff)
		else $error("command inside dll lock time");
	chk_lock_cke: assert property (lock_r && idle_r < 10'h1ff |-> cke)
		else $error("clock enable dropped during lock");
	chk_test_bit_zero: assert property (mrs && ba == 3'h0 |-> !a[7])
		else $error("test bit set in mode write");
	chk_mode_bank_code: assert property (mrs |-> ba <= 3'h2)
		else $error("mode write to unknown register");
	chk_nom_code_legal: assert property (mrs && ba == 3'h1 && !(a[7] && a[12]) |-> nom <= 3'h3)
		else $error("termination code not allowed");
	chk_dll_off_nom: assert property (mrs && ba == 3'h1 && a[0] |-> nom == 3'h0)
		else $error("termination left on with dll off");
	chk_dll_off_rttwr: assert property (mrs && ba == 3'h2 && off_r |-> a[10:9] == 2'h0)
		else $error("write termination on with dll off");
	chk_odt_held_low: assert property (!odt)
		else $error("termination pin raised");
	chk_chop_float: assert property ($rose(dq_d_oe) && chop_r |-> first_half ##1 second_half_off)
		else $error("chopped read drove past four beats");
	chk_full_burst: assert property ($rose(dq_d_oe) && !chop_r |-> first_half ##1 first_half)
		else $error("full read burst drive length wrong");
	chk_strobe_beats: assert property ($rose(dq_d_oe) |-> beat_pair ##1 beat_pair)
		else $error("strobe pattern wrong");
endmodule // dram_mode_asserts

// *** dram_mode_field_decode_bench.sv ***
// bench: controller and device face each other; orders go through the register port
// assumes one 100 MHz clock; expectations come from the mode field layout only
`timescale 1ns/1ps
module dram_mode_field_decode_bench;
	logic        mclk = 1'h0;
	logic        reset = 1'h1;
	logic [4:0]  reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'h0;
	logic        reg_rd = 1'h0;
	logic [31:0] reg_rdata, s;
	logic [5:0]  cas_latency, read_latency_total, autoprecharge_write_delay;
	logic [4:0]  write_recovery_cycles;
	logic [2:0]  rtt_nom_code;
	logic [1:0]  burst_mode, drive_select, rtt_wr_code;
	logic        burst_interleave, test_mode, dll_reset_bit, fast_powerdown_exit;
	logic        dll_running, internal_write_start;
	logic        oe_q = 1'h0;
	logic        saw_rst = 1'h0;
	logic [63:0] last_rd = 64'h0;
	int          n_fail = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          wcnt = 0;
	int          wgap = 0;
	int          gap8 = 0;
	dram_cmd_if bus_if ();
	dram_mode_device dram_mode_device_inst (.mclk, .reset, .bus(bus_if), .cas_latency,
		.read_latency_total, .burst_mode, .burst_interleave, .test_mode, .dll_reset_bit,
		.write_recovery_cycles, .autoprecharge_write_delay, .fast_powerdown_exit,
		.dll_running, .drive_select, .rtt_nom_code, .rtt_wr_code, .internal_write_start);
	dram_mode_controller dram_mode_controller_inst (.mclk, .reset, .bus(bus_if), .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	dram_mode_asserts dram_mode_asserts_inst (.mclk, .reset, .cke(bus_if.cke),
		.cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n),
		.odt(bus_if.odt), .ba(bus_if.ba), .a(bus_if.a), .dq_d_oe(bus_if.dq_d_oe),
		.dqs_d(bus_if.dqs_d));
	always #5 mclk = ~mclk;
	// write start measured from the first driven beat, so latency settings drop out
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		oe_q <= bus_if.dq_h_oe;
		wcnt <= (bus_if.dq_h_oe && !oe_q) ? 0 : wcnt + 1;
		if (internal_write_start === 1'h1)
			wgap <= wcnt;
		if (dll_reset_bit === 1'h1)
			saw_rst <= 1'h1;
		if (cycles == 20000) begin
			n_fail++;
			close_out();
		end
	end
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] ad, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask
	task automatic rdr(input logic [4:0] ad, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= ad;
		reg_rd <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask
	// poll busy with a bound; the dll lock wait is the longest case
	task automatic issue(input logic [18:0] ba_a, input logic [3:0] kind);
		int i;
		wr(dram_mode_pkg::REG_ADDR, {13'h0, ba_a});
		wr(dram_mode_pkg::REG_CMD, {28'h0, kind});
		s = 32'h1;
		for (i = 0; i < 600 && s[0] !== 1'h0; i++)
			rdr(dram_mode_pkg::REG_STATUS, s);
		check(s[0], 1'h0);
	endtask
	task automatic mrs(input logic [18:0] v);
		issue(v, {1'h0, dram_mode_pkg::CMD_MRS});
	endtask
	function automatic logic [2:0] col(input logic [2:0] c, input logic [2:0] p, input logic il);
		return il ? c ^ p : {c[2] ^ p[2], c[1:0] + p[1:0]};
	endfunction
	// stored byte of column c is 8'ha0 + c; chopped slots keep the previous read's bytes
	task automatic rd_burst(input logic [2:0] c, input logic il, input logic chop);
		logic [31:0] lo;
		logic [31:0] hi;
		logic [63:0] e;
		int p;
		issue({16'h0, c}, {chop, dram_mode_pkg::CMD_READ});
		rdr(dram_mode_pkg::REG_RDATA_LO, lo);
		rdr(dram_mode_pkg::REG_RDATA_HI, hi);
		for (p = 0; p < 8; p++)
			e[8*p +: 8] = (chop && p > 3) ? last_rd[8*p +: 8] : {5'h14, col(c, 3'(p), il)};
		check({hi, lo}, e);
		last_rd = e;
	endtask
	task automatic wr_burst(input logic [31:0] lo, input logic [2:0] c, input logic chop);
		wr(dram_mode_pkg::REG_WDATA_LO, lo);
		wr(dram_mode_pkg::REG_WDATA_HI, 32'ha7a6a5a4);
		issue({16'h0, c}, {chop, dram_mode_pkg::CMD_WRITE});
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		reset <= 1'h0;
		rdr(dram_mode_pkg::REG_STATUS, s);
		check(s, 32'h0);
		rdr(5'h1c, s);
		check(s, 32'h0);
		issue(19'h0, {1'h0, dram_mode_pkg::CMD_PD_OUT});
		mrs(19'h017d0);
		check({cas_latency, read_latency_total}, {6'h09, 6'h09});
		check({test_mode, burst_mode, fast_powerdown_exit}, {1'h0, 2'h0, 1'h1});
		check({write_recovery_cycles, autoprecharge_write_delay}, {5'h08, 6'h0a});
		check(dll_reset_bit, 1'h0);
		check(saw_rst, 1'h1);
		wr_burst(32'ha3a2a1a0, 3'h3, 1'h0);
		gap8 = wgap;
		rd_burst(3'h1, 1'h0, 1'h0);
		rd_burst(3'h6, 1'h0, 1'h0);
		mrs(19'h0000d);
		check({cas_latency, burst_mode, burst_interleave}, {6'h0c, 2'h1, 1'h1});
		check({fast_powerdown_exit, write_recovery_cycles}, {1'h0, 5'h05});
		mrs(19'h10068);
		check({cas_latency, read_latency_total}, {6'h0c, 6'h17});
		check({drive_select, rtt_nom_code, dll_running}, {2'h2, 3'h2, 1'h1});
		rd_burst(3'h3, 1'h1, 1'h0);
		rd_burst(3'h5, 1'h1, 1'h1);
		wr_burst(32'ha7a6a5a4, 3'h4, 1'h1);
		check(wgap, gap8);
		rd_burst(3'h0, 1'h1, 1'h0);
		mrs(19'h10205);
		check({rtt_nom_code, dll_running}, {3'h0, 1'h0});
		mrs(19'h20200);
		check(rtt_wr_code, 2'h0);
		mrs(19'h10068);
		mrs(19'h20200);
		check(rtt_wr_code, 2'h1);
		issue(19'h0, {1'h0, dram_mode_pkg::CMD_SREF_IN});
		check(dll_running, 1'h0);
		issue(19'h0, {1'h0, dram_mode_pkg::CMD_SREF_OUT});
		check(dll_running, 1'h1);
		issue(19'h0, {1'h0, dram_mode_pkg::CMD_PD_IN});
		check(dll_running, 1'h0);
		issue(19'h0, {1'h0, dram_mode_pkg::CMD_PD_OUT});
		rdr(dram_mode_pkg::REG_STATUS, s);
		check(s, 32'h2);
		mrs(19'h00002);
		check(burst_mode, 2'h2);
		wr_burst(32'ha3a2a1a0, 3'h0, 1'h0);
		check(wgap, gap8 - 2);
		rd_burst(3'h6, 1'h0, 1'h1);
		close_out();
	end
endmodule // dram_mode_field_decode_bench
